// ==== hdl/acb_regs.svh ====
`ifndef ACB_REGS_SVH
`define ACB_REGS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define ACB_OFS_IRQ_ENABLE_CLEAR 8'h00
`define ACB_OFS_IRQ_ENABLE_SET 8'h04
`define ACB_OFS_IRQ_FLAGS 8'h08
`define ACB_OFS_SYNC_BUSY_FLAGS 8'h0C
`define ACB_OFS_GAIN_CORRECTION 8'h10
`define ACB_OFS_OFFSET_CORRECTION 8'h14
`define ACB_OFS_RESULT 8'h18
`define ACB_OFS_AVG_CTRL 8'h1C

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ACB_IRQ_RESULT_READY 0
`define ACB_IRQ_WINDOW_HIT 1
`define ACB_IRQ_OVERRUN 2
`define ACB_BUSY_GAIN 0
`define ACB_BUSY_OFFSET 1

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define ACB_RST_GAIN 12'h000
`define ACB_RST_OFFSET 12'h000
`define ACB_RST_AVG 4'h0

`endif

// ==== hdl/acb_pkg.sv ====
package acb_pkg;
  // Correction pair as applied to the converter.
  typedef struct packed {
    logic [11:0] gain;
    logic [11:0] offset;
  } acb_corr_t;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } acb_bus_t;

  typedef enum logic [1:0] {ACB_IDLE, ACB_CONV, ACB_HOLD} acb_state_t;
endpackage

// ==== hdl/acb_top.sv ====
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "acb_regs.svh"

module acb_top #(
  parameter int RES_W = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire acb_pkg::acb_bus_t bus,
  output logic [31:0] rdata,
  input wire logic conv_start,
  input wire logic sample_done,
  input wire logic [RES_W-1:0] sample_data,
  input wire logic window_match,
  output logic conv_busy,
  output acb_pkg::acb_corr_t corr_active,
  output logic dma_result_ready,
  output logic irq,
  output logic wake_req
);

  // ------------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------------
  function automatic logic hit(input acb_pkg::acb_bus_t b, input logic [7:0] ofs);
    hit = b.addr == ofs;
  endfunction

  logic wr_gain, wr_ofs, wr_set, wr_clr, wr_flag, wr_avg, rd_res;
  assign wr_gain = bus.wr && hit(bus, `ACB_OFS_GAIN_CORRECTION);
  assign wr_ofs = bus.wr && hit(bus, `ACB_OFS_OFFSET_CORRECTION);
  assign wr_set = bus.wr && hit(bus, `ACB_OFS_IRQ_ENABLE_SET);
  assign wr_clr = bus.wr && hit(bus, `ACB_OFS_IRQ_ENABLE_CLEAR);
  assign wr_flag = bus.wr && hit(bus, `ACB_OFS_IRQ_FLAGS);
  assign wr_avg = bus.wr && hit(bus, `ACB_OFS_AVG_CTRL);
  assign rd_res = bus.rd && hit(bus, `ACB_OFS_RESULT);

  // ------------------------------------------------------------------
  // Averaging control register
  // ------------------------------------------------------------------
  logic [3:0] avg_r, avg_nxt;

  always_comb begin
    avg_nxt = avg_r;
    if (wr_avg) begin
      avg_nxt = bus.wdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avg_r <= `ACB_RST_AVG;
    end else begin
      avg_r <= avg_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------------
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] cnt_inc;
  logic [15:0] cnt_goal;
  logic [RES_W+15:0] acc_r, acc_nxt;
  logic [RES_W+15:0] acc_sum;
  logic [RES_W-1:0] result_r, result_nxt;
  acb_pkg::acb_state_t st_r, st_nxt;
  logic result_evt;

  // Count and running sum are shared by the last-sample test and the stored result.
  assign cnt_inc = cnt_r + 16'h0001;
  assign cnt_goal = 16'h0001 << avg_r;
  assign acc_sum = acc_r + (RES_W+16)'(sample_data);

  always_comb begin
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    result_nxt = result_r;
    st_nxt = st_r;
    result_evt = 1'b0;
    unique case (st_r)
      acb_pkg::ACB_IDLE: begin
        if (conv_start) begin
          st_nxt = acb_pkg::ACB_CONV;
          cnt_nxt = 16'h0000;
          acc_nxt = '0;
        end
      end
      acb_pkg::ACB_CONV: begin
        if (sample_done) begin
          acc_nxt = acc_sum;
          cnt_nxt = cnt_inc;
          // Samples before the last of an averaging run never raise the result event.
          if (cnt_inc >= cnt_goal) begin
            result_nxt = RES_W'(acc_sum >> avg_r);
            result_evt = 1'b1;
            st_nxt = acb_pkg::ACB_HOLD;
          end
        end
      end
      acb_pkg::ACB_HOLD: begin
        // Pending corrections were applied on the result edge; restart is now safe.
        st_nxt = acb_pkg::ACB_IDLE;
      end
      default: begin
        st_nxt = acb_pkg::ACB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      acc_r <= '0;
      result_r <= '0;
      st_r <= acb_pkg::ACB_IDLE;
    end else begin
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      result_r <= result_nxt;
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Correction shadow and busy bits
  // ------------------------------------------------------------------
  acb_pkg::acb_corr_t shadow_r, shadow_nxt, active_r, active_nxt;
  logic [1:0] busy_r, busy_nxt;

  always_comb begin
    shadow_nxt = shadow_r;
    active_nxt = active_r;
    busy_nxt = busy_r;
    if (result_evt) begin
      if (busy_r[`ACB_BUSY_GAIN]) begin
        active_nxt.gain = shadow_r.gain;
        busy_nxt[`ACB_BUSY_GAIN] = 1'b0;
      end
      if (busy_r[`ACB_BUSY_OFFSET]) begin
        active_nxt.offset = shadow_r.offset;
        busy_nxt[`ACB_BUSY_OFFSET] = 1'b0;
      end
    end
    if (wr_gain) begin
      shadow_nxt.gain = bus.wdata[11:0];
      busy_nxt[`ACB_BUSY_GAIN] = 1'b1;
    end
    if (wr_ofs) begin
      shadow_nxt.offset = bus.wdata[11:0];
      busy_nxt[`ACB_BUSY_OFFSET] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_r <= {`ACB_RST_GAIN, `ACB_RST_OFFSET};
      active_r <= {`ACB_RST_GAIN, `ACB_RST_OFFSET};
      busy_r <= 2'h0;
    end else begin
      shadow_r <= shadow_nxt;
      active_r <= active_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Result-ready DMA request
  // ------------------------------------------------------------------
  logic dma_r, dma_nxt;
  logic overrun_evt;

  always_comb begin
    dma_nxt = dma_r;
    // A result that finds the previous one still unread is an overrun.
    overrun_evt = result_evt && dma_r && !rd_res;
    if (rd_res) begin
      dma_nxt = 1'b0;
    end
    if (result_evt) begin
      dma_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dma_r <= 1'b0;
    end else begin
      dma_r <= dma_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt enables
  // ------------------------------------------------------------------
  logic [2:0] en_r, en_nxt;

  always_comb begin
    en_nxt = en_r;
    if (wr_set) begin
      en_nxt = en_nxt | bus.wdata[2:0];
    end
    if (wr_clr) begin
      en_nxt = en_nxt & ~bus.wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 3'h0;
    end else begin
      en_r <= en_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt flags
  // ------------------------------------------------------------------
  logic [2:0] flags_r, flags_nxt, evt;

  assign evt = {overrun_evt, result_evt && window_match, result_evt};

  always_comb begin
    flags_nxt = flags_r;
    if (wr_flag) begin
      flags_nxt = flags_nxt & ~bus.wdata[2:0];
    end
    // Events are merged last so that they win over a clear in the same cycle.
    flags_nxt = flags_nxt | evt;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= 3'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (bus.rd) begin
      unique case (bus.addr)
        `ACB_OFS_IRQ_ENABLE_SET, `ACB_OFS_IRQ_ENABLE_CLEAR: rdata_nxt[2:0] = en_r;
        `ACB_OFS_IRQ_FLAGS: rdata_nxt[2:0] = flags_r;
        `ACB_OFS_SYNC_BUSY_FLAGS: rdata_nxt[1:0] = busy_r;
        `ACB_OFS_GAIN_CORRECTION: rdata_nxt[11:0] = shadow_r.gain;
        `ACB_OFS_OFFSET_CORRECTION: rdata_nxt[11:0] = shadow_r.offset;
        `ACB_OFS_RESULT: rdata_nxt[RES_W-1:0] = result_r;
        `ACB_OFS_AVG_CTRL: rdata_nxt[3:0] = avg_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Requests are combinational from flag and enable so they drop with either.
  logic [2:0] req;
  assign req = flags_r & en_r;
  assign irq = |req;
  assign wake_req = req[`ACB_IRQ_RESULT_READY] | req[`ACB_IRQ_WINDOW_HIT];
  assign rdata = rdata_r;
  assign dma_result_ready = dma_r;
  assign corr_active = active_r;
  assign conv_busy = st_r != acb_pkg::ACB_IDLE;

endmodule

// ==== test/acb_checker.sv ====
`timescale 1ns/1ps
`include "acb_regs.svh"
module acb_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire acb_pkg::acb_bus_t bus,
  input wire logic sample_done,
  input wire acb_pkg::acb_corr_t corr_active,
  input wire logic dma_result_ready,
  input wire logic irq,
  input wire logic wake_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd_res = bus.rd && bus.addr == `ACB_OFS_RESULT;
  property p_dma_up; $rose(dma_result_ready) |-> $past(sample_done); endproperty
  a_dma_up: assert property (p_dma_up) else $error("dma request early");
  property p_dma_on; dma_result_ready && !rd_res |=> dma_result_ready; endproperty
  a_dma_on: assert property (p_dma_on) else $error("dma request lost");
  property p_dma_off; rd_res && !sample_done |=> !dma_result_ready; endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma request stuck");
  property p_corr; !$stable(corr_active) |-> $past(sample_done) && dma_result_ready; endproperty
  a_corr: assert property (p_corr) else $error("correction moved early");
  property p_wake; wake_req |-> irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without request");
  property p_irq_on; irq && !bus.wr |=> irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("request dropped");
  property p_irq_off;
    bus.wr && bus.addr == `ACB_OFS_IRQ_ENABLE_CLEAR && bus.wdata[2:0] == 3'h7 |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request after disable");
  property p_irq_up; $rose(irq) |-> $past(bus.wr) || $past(sample_done); endproperty
  a_irq_up: assert property (p_irq_up) else $error("request without cause");
endmodule
bind acb_top acb_checker i_acb_checker (.mclk(mclk), .rst_n(rst_n), .bus(bus),
  .sample_done(sample_done), .corr_active(corr_active),
  .dma_result_ready(dma_result_ready), .irq(irq), .wake_req(wake_req));

// ==== test/acb_dma_model.sv ====
`timescale 1ns/1ps
`include "acb_regs.svh"
module acb_dma_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic dma_result_ready,
  input wire logic [31:0] rdata,
  output acb_pkg::acb_bus_t req,
  output logic [31:0] got
);
  logic rd_d;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
      rd_d <= 1'b0;
      got <= 32'h0;
    end else begin
      rd_d <= req.rd;
      if (rd_d) got <= rdata;
      req.addr <= `ACB_OFS_RESULT;
      req.rd <= en && dma_result_ready && !req.rd && !rd_d;
    end
  end
endmodule

// ==== test/acb_top_tb.sv ====
`timescale 1ns/1ps
`include "acb_regs.svh"
module acb_top_tb;
  logic mclk = 0;
  logic rst_n = 0;
  logic conv_start = 0;
  logic sample_done = 0;
  logic window_match = 0;
  logic dma_en = 0;
  logic dma_x = 0;
  logic [11:0] sample_data = 12'h000;
  logic [11:0] gain;
  logic [11:0] off;
  logic [31:0] rdata;
  logic [31:0] dma_got;
  logic conv_busy, dma, irq, wake;
  acb_pkg::acb_bus_t bus = '0;
  acb_pkg::acb_bus_t dma_bus;
  acb_pkg::acb_corr_t corr;
  int num_errors = 0, comparisons = 0, seed = 75658, flags = 0, en = 0, res = 0, avg = 0;
  always #2 mclk = ~mclk;
  acb_top i_acb_top (.mclk(mclk), .rst_n(rst_n), .bus(dma_en ? dma_bus : bus), .rdata(rdata),
    .conv_start(conv_start), .sample_done(sample_done), .sample_data(sample_data),
    .window_match(window_match), .conv_busy(conv_busy), .corr_active(corr),
    .dma_result_ready(dma), .irq(irq), .wake_req(wake));
  acb_dma_model i_acb_dma_model (.mclk(mclk), .rst_n(rst_n), .en(dma_en),
    .dma_result_ready(dma), .rdata(rdata), .req(dma_bus), .got(dma_got));
  task chk(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus <= '0;
    #1;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge mclk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk) bus <= '0;
    #1 chk(rdata, e);
  endtask
  task lv;
    chk(irq, (flags & en) != 0);
    chk(wake, (flags & en & 3) != 0);
  endtask
  task conv(int n, bit wm);
    int s;
    int sum;
    sum = 0;
    @(posedge mclk) conv_start <= 1;
    @(posedge mclk) conv_start <= 0;
    #1 chk(conv_busy, 1);
    repeat (n) begin
      s = $random(seed) & 32'hFFF;
      sum += s;
      @(posedge mclk) sample_done <= 1;
      sample_data <= s[11:0];
      window_match <= wm;
      #1 chk(dma, dma_x);
    end
    @(posedge mclk) sample_done <= 0;
    #1;
    if (dma_x) flags |= 4;
    flags |= wm ? 3 : 1;
    dma_x = 1;
    res = sum >> avg;
    chk(dma, 1);
    chk(corr, {gain, off});
  endtask
  task finish_test;
    $display("Counts: %0d mismatches in %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #4000;
    num_errors++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    gain = 12'($random(seed));
    off = 12'($random(seed));
    chk(conv_busy, 0);
    rd(`ACB_OFS_SYNC_BUSY_FLAGS, 0);
    wr(`ACB_OFS_GAIN_CORRECTION, gain);
    wr(`ACB_OFS_OFFSET_CORRECTION, off);
    rd(`ACB_OFS_SYNC_BUSY_FLAGS, 3);
    chk(corr, 0);
    conv(1, 0);
    rd(`ACB_OFS_SYNC_BUSY_FLAGS, 0);
    rd(`ACB_OFS_IRQ_FLAGS, 1);
    lv;
    rd(`ACB_OFS_RESULT, res);
    dma_x = 0;
    chk(dma, 0);
    $display("buffering test done");
    avg = 2;
    wr(`ACB_OFS_AVG_CTRL, 2);
    conv(4, 0);
    avg = 0;
    wr(`ACB_OFS_AVG_CTRL, 0);
    conv(1, 1);
    rd(`ACB_OFS_IRQ_FLAGS, flags);
    $display("averaging test done");
    wr(`ACB_OFS_IRQ_ENABLE_SET, 7);
    en = 7;
    lv;
    wr(`ACB_OFS_IRQ_ENABLE_CLEAR, 3);
    en = 4;
    lv;
    wr(`ACB_OFS_IRQ_FLAGS, 4);
    flags = 3;
    lv;
    wr(`ACB_OFS_IRQ_ENABLE_SET, 1);
    en = 5;
    lv;
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 0);
    @(posedge mclk) dma_en <= 1;
    for (int i = 0; i < 20 && dma; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    dma_en <= 0;
    #1 chk(dma_got, res);
    wr(`ACB_OFS_IRQ_FLAGS, 7);
    flags = 0;
    lv;
    $display("interrupt test done");
    finish_test;
  end
endmodule
